// >>> rtl/fctl_pkg.sv
// Contract
// - host writes reset command after failure
// - monitor window flag unless gaps under 50us
// - confirm acceptance before reading window flag
// - check window flag before and after add
// - status reads use a valid operation address
package fctl_pkg;
  // clock and timing
  localparam int CLK_NS = 4;
  localparam int T_STROBE_NS = 150;
  localparam int T_FLOAT_NS = 35;
  localparam int GAP_US = 50;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLOAT_CYC = (T_FLOAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC = GAP_US * 1000 / CLK_NS;
  localparam int GAP_W = 16;
  localparam int CNT_W = 8;
  // flash bus widths and status bit positions
  localparam int FA_W = 20;
  localparam int DQ_W = 16;
  localparam int B_POLL = 7;
  localparam int B_TOG1 = 6;
  localparam int B_TLIM = 5;
  localparam int B_EWIN = 3;
  localparam int B_TOG2 = 2;
  // unlock addresses and command bytes
  localparam logic [FA_W-1:0] UA1 = 20'h00555;
  localparam logic [FA_W-1:0] UA2 = 20'h002AA;
  localparam logic [7:0] C_UNL1 = 8'hAA;
  localparam logic [7:0] C_UNL2 = 8'h55;
  localparam logic [7:0] C_PROG = 8'hA0;
  localparam logic [7:0] C_ERASE = 8'h80;
  localparam logic [7:0] C_CHIP = 8'h10;
  localparam logic [7:0] C_SECT = 8'h30;
  localparam logic [7:0] C_SUSP = 8'hB0;
  localparam logic [7:0] C_RESUME = 8'h30;
  localparam logic [7:0] C_RST = 8'hF0;
  localparam logic [2:0] IDX_TAIL = 3'h5;
  localparam logic [2:0] IDX_PDATA = 3'h3;
  // register map
  localparam int AX_W = 8;
  localparam logic [AX_W-1:0] A_CMD = 8'h00;
  localparam logic [AX_W-1:0] A_ADDR = 8'h04;
  localparam logic [AX_W-1:0] A_WDATA = 8'h08;
  localparam logic [AX_W-1:0] A_RDATA = 8'h0C;
  localparam logic [AX_W-1:0] A_STAT = 8'h10;
  localparam logic [AX_W-1:0] A_IRQ = 8'h14;
  localparam logic [AX_W-1:0] A_MASK = 8'h18;
  localparam logic [AX_W-1:0] A_CFG = 8'h1C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // interrupt status bits
  localparam int IRQ_W = 4;
  localparam int I_DONE = 0;
  localparam int I_FAIL = 1;
  localparam int I_REJ = 2;
  localparam int I_ERUN = 3;
  // status register bits
  localparam int S_BUSY = 0;
  localparam int S_PEND = 1;
  localparam int S_RUN = 2;
  localparam int S_TLIM = 3;
  localparam int S_EWIN = 4;
  localparam int S_RDY = 5;

  typedef enum logic [2:0] {
    OP_READ = 3'b000, OP_PROG = 3'b001, OP_SECT = 3'b010,
    OP_CHIP = 3'b011, OP_SUSP = 3'b100, OP_RESUME = 3'b101,
    OP_RESET = 3'b110, OP_POLL = 3'b111
  } op_e;

  // one command write of a sequence: {last, address, data}
  function automatic logic [FA_W+DQ_W:0] seq_step(op_e op, logic [2:0] i,
    logic [FA_W-1:0] a, logic [DQ_W-1:0] d);
    logic [FA_W-1:0] sa;
    logic [7:0] sd;
    sa = UA1;
    sd = C_CHIP;
    unique case (i)
      3'h0: sd = C_UNL1;
      3'h1: begin sa = UA2; sd = C_UNL2; end
      3'h2: sd = (op == OP_PROG) ? C_PROG : C_ERASE;
      3'h3: sd = C_UNL1;
      3'h4: begin sa = UA2; sd = C_UNL2; end
      default: if (op == OP_SECT)
      begin
        sa = a;
        sd = C_SECT;
      end
    endcase
    if (op == OP_PROG && i == IDX_PDATA)
      return {1'b1, a, d};
    if (op == OP_SUSP || op == OP_RESUME || op == OP_RESET)
      return {1'b1, a, DQ_W'(op == OP_SUSP ? C_SUSP :
        op == OP_RESUME ? C_RESUME : C_RST)};
    return {i == IDX_TAIL, sa, DQ_W'(sd)};
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] v,
    logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++)
      if (s[b])
        m[b*8 +: 8] = v[b*8 +: 8];
    return m;
  endfunction
endpackage

// >>> rtl/flash_cycle.sv
`timescale 1ns/1ps
`default_nettype none
module flash_cycle
  import fctl_pkg::*;
#(
  parameter int STROBE = STROBE_CYC,
  parameter int FLOAT = FLOAT_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic wr,
  input wire logic [FA_W-1:0] addr,
  input wire logic [DQ_W-1:0] wdata,
  input wire logic [DQ_W-1:0] dq_in,
  output logic done,
  output logic [DQ_W-1:0] rdata,
  output logic [FA_W-1:0] fa,
  output logic [DQ_W-1:0] dq_out,
  output logic dq_oe,
  output logic ce_n,
  output logic oe_n,
  output logic we_n
);
  typedef enum logic [1:0] {
    C_IDLE = 2'b00, C_SETUP = 2'b01, C_STROBE = 2'b10, C_FLOAT = 2'b11
  } cyc_e;
  typedef struct packed {
    cyc_e st;
    logic [CNT_W-1:0] cnt;
    logic wr;
    logic done;
    logic [DQ_W-1:0] rdata;
    logic [FA_W-1:0] fa;
    logic [DQ_W-1:0] dq_out;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } cyc_s;
  cyc_s r, n;

  //////////////////////////////////////////////////////////////////////
  // one async bus cycle: setup, strobe, float before the next
  always_comb
  begin
    n = r;
    n.done = 1'b0;
    unique case (r.st)
      C_IDLE: if (start)
      begin
        n.st = C_SETUP;
        n.wr = wr;
        n.fa = addr;
        n.dq_out = wdata;
        n.dq_oe = wr;
        n.ce_n = 1'b0;
      end
      C_SETUP:
      begin
        n.st = C_STROBE;
        n.cnt = CNT_W'(STROBE - 1);
        n.oe_n = r.wr;
        n.we_n = ~r.wr;
      end
      C_STROBE: if (r.cnt == '0)
      begin
        // sample at the very end of the strobe, data settled by then
        if (!r.wr)
          n.rdata = dq_in;
        n.st = C_FLOAT;
        n.cnt = CNT_W'(FLOAT - 1);
        n.oe_n = 1'b1;
        n.we_n = 1'b1;
        n.ce_n = 1'b1;
      end
      else
        n.cnt = r.cnt - 1'b1;
      C_FLOAT: if (r.cnt == '0)
      begin
        // data held past the write strobe to keep hold time
        n.st = C_IDLE;
        n.dq_oe = 1'b0;
        n.done = 1'b1;
      end
      else
        n.cnt = r.cnt - 1'b1;
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      r <= '{st: C_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    else
      r <= n;
  end

  assign done = r.done;
  assign rdata = r.rdata;
  assign fa = r.fa;
  assign dq_out = r.dq_out;
  assign dq_oe = r.dq_oe;
  assign ce_n = r.ce_n;
  assign oe_n = r.oe_n;
  assign we_n = r.we_n;

  strobe_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(oe_n) |-> !oe_n [*8] ##1 !ce_n)
    else $error("read strobe too short");
  strobe_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(!oe_n && !we_n) && (!ce_n || (oe_n && we_n)))
    else $error("strobes overlap or strobe without chip enable");
endmodule // flash_cycle
`default_nettype wire

// >>> rtl/flash_ctl.sv
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module flash_ctl
  import fctl_pkg::*;
#(
  parameter int GAP_CYCLES = GAP_CYC,
  parameter int STROBE = STROBE_CYC,
  parameter int FLOAT = FLOAT_CYC
)
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [AX_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [AX_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic IRQ,
  output logic [FA_W-1:0] FLASH_ADDR,
  input wire logic [DQ_W-1:0] FLASH_DQ_IN,
  output logic [DQ_W-1:0] FLASH_DQ_OUT,
  output logic FLASH_DQ_OE,
  output logic FLASH_CE_N,
  output logic FLASH_OE_N,
  output logic FLASH_WE_N,
  input wire logic READY_BUSY_N
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_SEQ = 3'b001, ST_PRE = 3'b010, ST_TOG_A = 3'b011,
    ST_TOG_B = 3'b100, ST_FLAG = 3'b101, ST_RD = 3'b110, ST_FIN = 3'b111
  } st_e;
  typedef struct packed {
    st_e st;
    op_e op;
    logic [2:0] idx;
    logic add;
    logic recheck;
    logic tog;
    logic fail;
    logic [FA_W-1:0] addr;
    logic [DQ_W-1:0] wdata;
    logic [DQ_W-1:0] rdata;
    logic erase_pend;
    logic erase_run;
    logic tlim;
    logic ewin;
    logic skip_cfg;
    logic [GAP_W-1:0] gap;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic aw_got;
    logic w_got;
    logic [AX_W-1:0] awaddr;
    logic [31:0] wdat;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdat;
    logic [1:0] rresp;
    logic cstart;
    logic cwr;
    logic [FA_W-1:0] caddr;
    logic [DQ_W-1:0] cdata;
  } ctl_s;
  ctl_s r, n;
  logic cyc_done;
  logic [DQ_W-1:0] cyc_rdata;
  logic [IRQ_W-1:0] set;
  logic go_rd, go_wr, cmd_go, skip_ok, tog_diff;
  logic [FA_W+DQ_W:0] stp;
  logic [FA_W+DQ_W:0] cur;

  // pin engine, all pin outputs come from its flops
  flash_cycle #(.STROBE(STROBE), .FLOAT(FLOAT)) flash_cycle_i (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .start(r.cstart),
    .wr(r.cwr),
    .addr(r.caddr),
    .wdata(r.cdata),
    .dq_in(FLASH_DQ_IN),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fa(FLASH_ADDR),
    .dq_out(FLASH_DQ_OUT),
    .dq_oe(FLASH_DQ_OE),
    .ce_n(FLASH_CE_N),
    .oe_n(FLASH_OE_N),
    .we_n(FLASH_WE_N)
  );

  assign skip_ok = r.skip_cfg && r.gap < GAP_W'(GAP_CYCLES);
  assign tog_diff = cyc_rdata[B_TOG1] != r.tog;
  // write now on the pins; its top bit marks the end of a sequence
  assign cur = seq_step(r.op, r.idx, r.addr, r.wdata);
  assign cmd_go = r.aw_got && r.w_got && !r.bvalid && r.awaddr == A_CMD &&
    r.wstrb[0];

  //////////////////////////////////////////////////////////////////////
  // sequencer, register slave and interrupt logic
  always_comb
  begin
    n = r;
    set = '0;
    go_rd = 1'b0;
    go_wr = 1'b0;
    n.cstart = 1'b0;
    // gap since the last sector command, saturating
    if (r.gap < GAP_W'(GAP_CYCLES))
      n.gap = r.gap + 1'b1;
    if (cyc_done)
      n.rdata = cyc_rdata;
    unique case (r.st)
      ST_IDLE: if (cmd_go)
      begin
        n.op = op_e'(r.wdat[2:0]);
        n.idx = '0;
        n.add = 1'b0;
        n.recheck = 1'b0;
        n.fail = 1'b0;
        if (n.op == OP_READ)
        begin
          n.st = ST_RD;
          go_rd = 1'b1;
        end
        else if (n.op == OP_POLL)
        begin
          n.st = ST_TOG_A;
          go_rd = 1'b1;
        end
        else if (n.op == OP_SECT && r.erase_run)
          set[I_REJ] = 1'b1;
        else if (n.op == OP_SECT && r.erase_pend)
        begin
          // window still open: add a sector with one tail write
          n.add = 1'b1;
          n.idx = IDX_TAIL;
          n.st = skip_ok ? ST_SEQ : ST_PRE;
          go_wr = skip_ok;
          go_rd = !skip_ok;
        end
        else
        begin
          n.st = ST_SEQ;
          go_wr = 1'b1;
        end
      end
      ST_SEQ: if (cyc_done)
      begin
        if (!cur[FA_W+DQ_W])
        begin
          n.idx = r.idx + 3'h1;
          go_wr = 1'b1;
        end
        else if (r.op == OP_SECT)
        begin
          n.gap = '0;
          n.st = r.add ? ST_FLAG : ST_TOG_A;
          go_rd = 1'b1;
        end
        else if (r.op == OP_PROG || r.op == OP_CHIP)
        begin
          n.st = ST_TOG_A;
          go_rd = 1'b1;
        end
        else
        begin
          if (r.op == OP_RESET)
          begin
            n.erase_pend = 1'b0;
            n.erase_run = 1'b0;
            set[I_FAIL] = r.fail;
          end
          n.st = ST_FIN;
        end
      end
      ST_PRE: if (cyc_done)
      begin
        n.ewin = cyc_rdata[B_EWIN];
        if (cyc_rdata[B_EWIN])
        begin
          // erase already under way, the add would be ignored
          set[I_REJ] = 1'b1;
          n.erase_pend = 1'b0;
          n.erase_run = 1'b1;
          n.st = ST_FIN;
        end
        else
        begin
          n.st = ST_SEQ;
          go_wr = 1'b1;
        end
      end
      ST_TOG_A: if (cyc_done)
      begin
        n.tog = cyc_rdata[B_TOG1];
        n.st = ST_TOG_B;
        go_rd = 1'b1;
      end
      ST_TOG_B: if (cyc_done)
      begin
        // only a toggling read carries the flag, once done the bit is data
        n.tlim = tog_diff && cyc_rdata[B_TLIM];
        if (r.op == OP_SECT)
        begin
          // acceptance shown by toggling, only then the flag is valid
          n.st = tog_diff ? ST_FLAG : ST_FIN;
          go_rd = tog_diff;
        end
        else if (!tog_diff)
        begin
          n.st = ST_FIN;
          if (r.op == OP_POLL)
          begin
            n.erase_pend = 1'b0;
            n.erase_run = 1'b0;
          end
        end
        else if (r.recheck)
        begin
          // still toggling with the limit flag up: failed, reset device
          n.fail = 1'b1;
          n.op = OP_RESET;
          n.idx = '0;
          n.st = ST_SEQ;
          go_wr = 1'b1;
        end
        else
        begin
          n.recheck = cyc_rdata[B_TLIM];
          n.st = ST_TOG_A;
          go_rd = 1'b1;
        end
      end
      ST_FLAG: if (cyc_done)
      begin
        n.ewin = cyc_rdata[B_EWIN];
        n.erase_run = cyc_rdata[B_EWIN];
        n.erase_pend = !cyc_rdata[B_EWIN];
        set[I_ERUN] = cyc_rdata[B_EWIN];
        set[I_REJ] = r.add && cyc_rdata[B_EWIN];
        n.st = ST_FIN;
      end
      ST_RD: if (cyc_done)
        n.st = ST_FIN;
      ST_FIN:
      begin
        set[I_DONE] = 1'b1;
        n.st = ST_IDLE;
      end
    endcase
    // launch a bus cycle; status reads always use the operation address
    stp = seq_step(n.op, n.idx, n.addr, n.wdata);
    if (go_rd || go_wr)
    begin
      n.cstart = 1'b1;
      n.cwr = go_wr;
      n.caddr = go_wr ? stp[FA_W+DQ_W-1:DQ_W] : n.addr;
      n.cdata = stp[DQ_W-1:0];
    end
    // write channel: address and data taken in either order
    if (r.bvalid && S_AXI_BREADY)
      n.bvalid = 1'b0;
    if (r.aw_got && r.w_got && !r.bvalid)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      unique case (r.awaddr)
        A_CMD: if (r.st != ST_IDLE && r.wstrb[0])
          set[I_REJ] = 1'b1;
        A_ADDR: n.addr = FA_W'(merge(32'(r.addr), r.wdat, r.wstrb));
        A_WDATA: n.wdata = DQ_W'(merge(32'(r.wdata), r.wdat, r.wstrb));
        A_IRQ: if (r.wstrb[0])
          n.irq_stat = r.irq_stat & ~r.wdat[IRQ_W-1:0];
        A_MASK: if (r.wstrb[0])
          n.irq_mask = r.wdat[IRQ_W-1:0];
        A_CFG: if (r.wstrb[0])
          n.skip_cfg = r.wdat[0];
        A_RDATA, A_STAT: ;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    if (r.awready && S_AXI_AWVALID)
    begin
      n.aw_got = 1'b1;
      n.awaddr = S_AXI_AWADDR;
    end
    if (r.wready && S_AXI_WVALID)
    begin
      n.w_got = 1'b1;
      n.wdat = S_AXI_WDATA;
      n.wstrb = S_AXI_WSTRB;
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    // read channel, answered on the same edge that takes the address
    if (r.rvalid && S_AXI_RREADY)
      n.rvalid = 1'b0;
    if (r.arready && S_AXI_ARVALID)
    begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdat = '0;
      unique case (S_AXI_ARADDR)
        A_CMD: n.rdat = 32'(r.op);
        A_ADDR: n.rdat = 32'(r.addr);
        A_WDATA: n.rdat = 32'(r.wdata);
        A_RDATA: n.rdat = 32'(r.rdata);
        A_STAT:
        begin
          n.rdat[S_BUSY] = r.st != ST_IDLE;
          n.rdat[S_PEND] = r.erase_pend;
          n.rdat[S_RUN] = r.erase_run;
          n.rdat[S_TLIM] = r.tlim;
          n.rdat[S_EWIN] = r.ewin;
          n.rdat[S_RDY] = READY_BUSY_N;
        end
        A_IRQ: n.rdat = 32'(r.irq_stat);
        A_MASK: n.rdat = 32'(r.irq_mask);
        A_CFG: n.rdat = 32'(r.skip_cfg);
        default: n.rresp = RESP_SLVERR;
      endcase
    end
    n.arready = !n.rvalid;
    // new events win over a clear in the same cycle
    n.irq_stat = n.irq_stat | set;
    n.irq = |(n.irq_stat & n.irq_mask);
  end

  // state register
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
      r <= '{st: ST_IDLE, op: OP_READ, gap: GAP_W'(GAP_CYCLES), default: '0};
    else
      r <= n;
  end

  assign S_AXI_AWREADY = r.awready;
  assign S_AXI_WREADY = r.wready;
  assign S_AXI_BRESP = r.bresp;
  assign S_AXI_BVALID = r.bvalid;
  assign S_AXI_ARREADY = r.arready;
  assign S_AXI_RDATA = r.rdat;
  assign S_AXI_RRESP = r.rresp;
  assign S_AXI_RVALID = r.rvalid;
  assign IRQ = r.irq;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  fail_reset_a: assert property (
    r.st == ST_TOG_B && cyc_done && r.recheck && tog_diff |=>
    r.st == ST_SEQ && r.op == OP_RESET ##[1:8] !FLASH_WE_N)
    else $error("failure not followed by reset command");
  gap_skip_a: assert property (
    $rose(r.st == ST_SEQ) && r.add |->
    $past(r.st) == ST_PRE || $past(skip_ok))
    else $error("flag check skipped outside the short gap");
  confirm_first_a: assert property (
    $rose(r.st == ST_FLAG) && !r.add |->
    $past(r.st) == ST_TOG_B && $past(tog_diff))
    else $error("window flag read before acceptance seen");
  flag_after_add_a: assert property (
    r.st == ST_SEQ && r.add && cyc_done |=>
    r.st == ST_FLAG ##[1:4] !FLASH_OE_N)
    else $error("no window flag check after added sector");
  poll_addr_a: assert property (
    r.st inside {ST_PRE, ST_TOG_A, ST_TOG_B, ST_FLAG} && !FLASH_OE_N |->
    FLASH_ADDR == r.addr)
    else $error("status read at wrong address");
  bvalid_hold_a: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");

  prog_done_c: cover property (r.op == OP_PROG && r.st == ST_FIN);
  sect_add_c: cover property (r.add && r.st == ST_FLAG && cyc_done);
  fail_c: cover property (r.fail && r.st == ST_FIN);
  reject_c: cover property (set[I_REJ]);
endmodule // flash_ctl
`default_nettype wire

// >>> tb/flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_model
  import fctl_pkg::*;
#(
  parameter int WIN = 1500,
  parameter int ERS = 4000,
  parameter int PGM = 200
)
(
  input wire logic clk,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [FA_W-1:0] addr,
  input wire logic [DQ_W-1:0] dq_out,
  input wire logic dq_oe,
  output logic [DQ_W-1:0] dq_in,
  output logic rb_n
);
  logic [DQ_W-1:0] mem [16];
  logic [DQ_W-1:0] st, last, pd;
  logic [15:0] sel;
  logic [7:0] prev, d;
  logic [3:0] pa, a;
  logic we_d, oe_d, ce_d, t6, t2, tl, hung, ovr, susp, ers;
  int pcnt, wcnt, ecnt, nsect, nrst;
  assign a = addr[3:0];
  assign d = dq_out[7:0];
  assign ers = (wcnt > 0 || ecnt > 0) && !susp;
  assign rb_n = !(pcnt > 0 || hung || ers);
  // released bus shows the inverse, not a stale copy
  assign dq_in = (oe_n || ce_n) ? ~last : st;
  initial
  begin
    foreach (mem[i])
      mem[i] = (i inside {[5:7]}) ? 16'h0025 : 16'hFFFF;
    {pcnt, wcnt, ecnt, nsect, nrst} = '0;
    {sel, prev, last, pd, pa, t6, t2, tl, hung, ovr, susp} = '0;
    {we_d, oe_d, ce_d} = 3'b111;
  end
  ////////////////////////////////////////////////////////////
  // status overlay on the array word
  always_comb
  begin
    st = mem[a];
    if (pcnt > 0 || hung)
      st[7:5] = {~pd[7], t6, tl};
    else if (ers)
    begin
      st[7:5] = {1'b0, t6, 1'b0};
      st[3] = (wcnt == 0);
      st[2] = t2;
    end
    else if (susp && sel[a])
    begin
      st[7:5] = {1'b1, t6, 1'b0};
      st[2] = t2;
    end
  end
  // timers each clock, toggles on the read strobe's fall, command decode on the write strobe's rise
  always @(posedge clk)
  begin
    we_d <= we_n;
    oe_d <= oe_n;
    ce_d <= ce_n;
    if (!oe_n && !ce_n)
      last <= st;
    if (oe_d && !oe_n && !ce_n)
    begin
      if (!rb_n)
        t6 <= ~t6;
      if (sel[a])
        t2 <= ~t2;
    end
    if (pcnt == 1 && ovr)
      {hung, tl} <= 2'b11;
    else if (pcnt == 1)
      mem[pa] <= pd;
    if (pcnt > 0)
      pcnt <= pcnt - 1;
    if (wcnt == 1)
      ecnt <= ERS;
    if (wcnt > 0 && !susp)
      wcnt <= wcnt - 1;
    if (ecnt > 0 && !susp)
      ecnt <= ecnt - 1;
    if (ecnt == 1 && !susp)
    begin
      foreach (mem[i])
        if (sel[i])
          mem[i] <= 16'hFFFF;
      sel <= '0;
    end
    // enable rises with the strobe, so look at the enable one edge back
    if (we_n && !we_d && !ce_d && dq_oe)
    begin
      prev <= d;
      if (hung)
      begin
        if (d == C_RST)
          {hung, tl, nrst} <= {2'b00, nrst + 1};
      end
      else if (susp)
        susp <= (d != C_RESUME);
      else if (ecnt > 0)
        susp <= (d == C_SUSP);
      else if (prev == C_PROG)
      begin
        {pa, pd, pcnt} <= {a, dq_out, PGM};
        ovr <= |(dq_out & ~mem[a]);
      end
      else if (d == C_SECT && (prev == C_UNL2 || wcnt > 0))
      begin
        sel[a] <= 1'b1;
        wcnt <= WIN;
        nsect <= nsect + 1;
      end
      else if (d == C_CHIP && prev == C_UNL2)
        {sel, ecnt} <= {16'hFFFF, ERS};
      else if (d == C_RST)
        nrst <= nrst + 1;
    end
  end
endmodule // flash_model
`default_nettype wire

// >>> tb/flash_ctl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_ctl_tb
  import fctl_pkg::*;
;
  logic clk, rst_n, awv, wv, bready, arv, rready, awr, wr, bv, arr, rv;
  logic irq, oe_n, ce_n, we_n, dqoe, rb_n;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, bseen, rseen;
  logic [3:0] mask;
  logic [FA_W-1:0] fa;
  logic [DQ_W-1:0] dqo, dqi;
  int mismatches, num_checks;
  localparam int WIN = 1500;
  flash_ctl #(.GAP_CYCLES(200), .STROBE(9), .FLOAT(2)) flash_ctl_i (
    .CORE_CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rready), .IRQ(irq), .FLASH_ADDR(fa),
    .FLASH_DQ_IN(dqi), .FLASH_DQ_OUT(dqo), .FLASH_DQ_OE(dqoe),
    .FLASH_CE_N(ce_n), .FLASH_OE_N(oe_n), .FLASH_WE_N(we_n),
    .READY_BUSY_N(rb_n));
  flash_model #(.WIN(WIN)) flash_model_i (.clk(clk), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .addr(fa), .dq_out(dqo), .dq_oe(dqoe),
    .dq_in(dqi), .rb_n(rb_n));
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, g);
      mismatches++;
    end
  endtask
  // write cycle: each channel dropped once taken, hold bready to response
  task automatic axw(input logic [7:0] ad, input logic [31:0] d);
    {awaddr, wdata, awv, wv, bready} <= {ad, d, 3'b111};
    do
    begin
      @(posedge clk);
      if (awr)
        awv <= 1'b0;
      if (wr)
        wv <= 1'b0;
    end
    while (!bv);
    bseen = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [7:0] ad, output logic [31:0] d);
    {araddr, arv, rready} <= {ad, 2'b11};
    do
    begin
      @(posedge clk);
      if (arr)
        arv <= 1'b0;
    end
    while (!rv);
    {d, rseen} = {rdata, rresp};
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // one controller op, wait for idle, then check and clear interrupts
  task automatic run(input logic [2:0] op, input logic [7:0] a,
    input logic [15:0] d, output logic [3:0] s);
    logic [31:0] v;
    axw(A_ADDR, {24'h0, a});
    axw(A_WDATA, {16'h0, d});
    axw(A_CMD, {29'h0, op});
    do
      axr(A_STAT, v);
    while (v[S_BUSY] !== 1'b0);
    axr(A_IRQ, v);
    s = v[3:0];
    chk("irq pin", |(s & mask), irq);
    axw(A_IRQ, v);
    @(posedge clk);
    chk("irq clear", 0, irq);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] v;
    axr(A_STAT, v);
    chk("status idle", 32'h20, v);
    axr(8'h20, v);
    chk("rresp", RESP_SLVERR, rseen);
    axw(8'h20, 32'h1);
    chk("bresp", RESP_SLVERR, bseen);
    axw(A_MASK, 32'h0);
    mask = 4'h0;
  endtask
  task automatic t_prog();
    logic [31:0] v;
    logic [3:0] s;
    run(3'h1, 8'h02, 16'h1234, s);
    chk("prog irq", 4'h1, s);
    chk("prog cell", 16'h1234, flash_model_i.mem[2]);
    axr(A_STAT, v);
    chk("prog limit", 0, v[S_TLIM]);
    run(3'h0, 8'h02, 16'h0, s);
    axr(A_RDATA, v);
    chk("read back", 32'h1234, v);
  endtask
  task automatic t_fail();
    logic [31:0] v;
    logic [3:0] s;
    int n;
    axw(A_MASK, 32'hF);
    mask = 4'hF;
    n = flash_model_i.nrst;
    run(3'h1, 8'h02, 16'h00FF, s);
    chk("fail irq", 1, s[I_FAIL]);
    chk("reset cmd", n + 1, flash_model_i.nrst);
    chk("cell kept", 16'h1234, flash_model_i.mem[2]);
    axr(A_STAT, v);
    chk("limit seen", 1, v[S_TLIM]);
  endtask
  task automatic t_erase();
    logic [31:0] v;
    logic [3:0] s;
    int n;
    n = flash_model_i.nsect;
    run(3'h2, 8'h05, 16'h0, s);
    chk("first sector", n + 1, flash_model_i.nsect);
    // short gap: the add skips the pre-check, the late add does not
    axw(A_CFG, 32'h1);
    run(3'h2, 8'h06, 16'h0, s);
    chk("added", n + 2, flash_model_i.nsect);
    chk("not refused", 0, s[I_REJ]);
    axr(A_STAT, v);
    chk("pend busy", 2'b10, {v[S_PEND], v[S_RDY]});
    repeat (WIN) @(posedge clk);
    run(3'h2, 8'h07, 16'h0, s);
    chk("late add", 1, s[I_REJ]);
    chk("no third", n + 2, flash_model_i.nsect);
    axr(A_STAT, v);
    chk("window flag", 1, v[S_EWIN]);
  endtask
  task automatic t_susp();
    logic [31:0] v;
    logic [3:0] s;
    run(3'h4, 8'h05, 16'h0, s);
    run(3'h0, 8'h05, 16'h0, s);
    axr(A_RDATA, v);
    chk("susp status", 2'b10, {v[7], v[5]});
    run(3'h0, 8'h02, 16'h0, s);
    axr(A_RDATA, v);
    chk("other sector", 32'h1234, v);
    axr(A_STAT, v);
    chk("ready susp", 1, v[S_RDY]);
    run(3'h5, 8'h05, 16'h0, s);
    run(3'h7, 8'h05, 16'h0, s);
    chk("erased", 32'hFFFF0025,
      {flash_model_i.mem[6], flash_model_i.mem[7]});
    run(3'h3, 8'h02, 16'h0, s);
    chk("chip irq", 4'h1, s);
    chk("chip erased", 16'hFFFF, flash_model_i.mem[2]);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // main sequence after a ten cycle reset
  initial
  begin
    {clk, rst_n, awv, wv, bready, arv, rready} = '0;
    {awaddr, araddr, wdata, mask, mismatches, num_checks} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_prog();
    t_fail();
    t_erase();
    t_susp();
    results();
  end
  // hang guard, well beyond the erase and poll spans
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule // flash_ctl_tb
`default_nettype wire
